// ===== gtli_map.vh
// Purpose: constants for the bus talker/listener interface
// Assumes: 100 MHz clock, bus lines active low
// Notes:   definitions only
`ifndef GTLI_MAP_VH
`define GTLI_MAP_VH
`define GTLI_LSN_BASE      8'h20
`define GTLI_TLK_BASE      8'h40
`define GTLI_GRP_MASK      8'h60
`define GTLI_SEC_BASE      8'h60
`define GTLI_UNL_CODE      8'h3F
`define GTLI_UNT_CODE      8'h5F
`define GTLI_ADR_W         5
`define GTLI_DATA_W        8
`define GTLI_FIFO_DEPTH    8
`define GTLI_SETTLE_NS     100
`define GTLI_CLK_NS        10
`define GTLI_SETTLE_CYC    ((`GTLI_SETTLE_NS + `GTLI_CLK_NS - 1) / `GTLI_CLK_NS)
`define GTLI_RST_IDLE      1'b1
`endif

// ===== gtli_fifo.v
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two
module gtli_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,      // clock
  input  wire             sys_rst_i,  // sync reset
  input  wire [WIDTH-1:0] in_data_i,  // write data
  input  wire             in_valid_i, // write request
  output wire             in_ready_o, // not full
  output wire [WIDTH-1:0] out_data_o, // head word
  output wire             out_valid_o,// not empty
  input  wire             out_ready_i // pop
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_ff;
  reg [AW:0]      rd_ptr_ff;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign full        = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                       (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty       = (wr_ptr_ff == rd_ptr_ff);
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_ptr_ff[AW-1:0]];

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ===== gtli_core.v
// Purpose: device-side talker/listener for an eight-bit parallel instrument bus
// Assumes: 100 MHz clk_i, open-drain bus pins, output enable low while driving low
// Notes:   response bytes queue in an 8-deep fifo before going out as talker
`include "gtli_map.vh"

module gtli_core (
  input  wire       clk_i,           // 100 MHz clock
  input  wire       sys_rst_i,       // sync reset, active high
  input  wire [4:0] prim_addr_i,     // primary address, static
  input  wire [7:0] dio_n_i,         // data lines in, low true
  output reg  [7:0] dio_n_o,         // data lines out value
  output reg  [7:0] dio_oe_n_o,      // data drive enable, low drives
  input  wire       atn_n_i,         // attention in
  input  wire       ifc_n_i,         // interface clear in
  input  wire       ren_n_i,         // remote enable in
  input  wire       eoi_n_i,         // end marker in
  output reg        eoi_n_o,         // end marker out value
  output reg        eoi_oe_n_o,      // end marker enable, low drives
  output reg        srq_n_o,         // service request value
  output reg        srq_oe_n_o,      // service request enable
  input  wire       dav_n_i,         // data valid in
  output reg        dav_n_o,         // data valid out value
  output reg        dav_oe_n_o,      // data valid enable
  input  wire       nrfd_n_i,        // not ready in
  output reg        nrfd_n_o,        // not ready out value
  output reg        nrfd_oe_n_o,     // not ready enable
  input  wire       ndac_n_i,        // not accepted in
  output reg        ndac_n_o,        // not accepted out value
  output reg        ndac_oe_n_o,     // not accepted enable
  input  wire [7:0] tx_data_i,       // response byte to send
  input  wire       tx_last_i,       // byte ends response
  input  wire       tx_valid_i,      // response byte offered
  output wire       tx_ready_o,      // fifo has room
  output reg  [7:0] rx_data_o,       // received data byte
  output reg        rx_eoi_o,        // byte came with end marker
  output reg        rx_valid_o,      // one-cycle received pulse
  output reg        rx_cmd_o,        // one-cycle command pulse
  output reg        is_listener_o,   // listener state
  output reg        is_talker_o,     // talker state
  output reg        remote_o         // remote enable seen
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PUT  = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_DAV  = 3'h3;
  localparam ST_DROP = 3'h4;
  localparam [7:0] SETTLE = `GTLI_SETTLE_CYC;

  // two-stage synchronisers for all incoming bus lines
  reg [12:0] sync1_ff;
  reg [12:0] sync2_ff;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1_ff <= 13'h1FFF;
      sync2_ff <= 13'h1FFF;
    end else begin
      sync1_ff <= {dio_n_i, atn_n_i, ifc_n_i, ren_n_i, eoi_n_i, dav_n_i};
      sync2_ff <= sync1_ff;
    end
  end
  reg [1:0] hs1_ff;
  reg [1:0] hs2_ff;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      hs1_ff <= 2'h3;
      hs2_ff <= 2'h3;
    end else begin
      hs1_ff <= {nrfd_n_i, ndac_n_i};
      hs2_ff <= hs1_ff;
    end
  end

  // true-level views of the synchronised lines
  wire [7:0] bus_byte = ~sync2_ff[12:5];
  wire       atn      = ~sync2_ff[4];
  wire       ifc      = ~sync2_ff[3];
  wire       ren      = ~sync2_ff[2];
  wire       eoi      = ~sync2_ff[1];
  wire       dav      = ~sync2_ff[0];
  wire       nrfd     = ~hs2_ff[1];
  wire       ndac     = ~hs2_ff[0];

  wire [7:0] my_lsn = `GTLI_LSN_BASE | {3'h0, prim_addr_i};
  wire [7:0] my_tlk = `GTLI_TLK_BASE | {3'h0, prim_addr_i};

  // response fifo
  wire [8:0] fifo_out;
  wire       fifo_valid;
  reg        fifo_pop;
  gtli_fifo #(
    .WIDTH (9),
    .DEPTH (`GTLI_FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // acceptor: 0 ready, 1 accepted (waiting for valid to go away)
  reg       acc_done_ff;
  reg       lsn_ff;
  reg       tlk_ff;
  reg [2:0] src_st_ff;
  reg [7:0] settle_ff;
  reg       atn_d_ff;

  wire acceptor_on = atn || lsn_ff; // every device accepts commands
  wire cap_now     = acceptor_on && dav && !acc_done_ff;
  // address decode on seven bits; the top data line plays no part
  wire [7:0] cmd7       = {1'b0, bus_byte[6:0]};
  wire [7:0] cmd_grp    = cmd7 & `GTLI_GRP_MASK;
  // secondary bytes match neither address and are ignored
  wire       is_sec     = (cmd_grp == `GTLI_SEC_BASE);
  wire       hit_unl    = (cmd7 == `GTLI_UNL_CODE);
  wire       hit_lsn    = (cmd7 == my_lsn);
  wire       hit_tlk    = (cmd7 == my_tlk);
  // any other talk-group byte, untalk included, means someone else talks
  wire       hit_othtlk = (cmd_grp == `GTLI_TLK_BASE) && !hit_tlk && !is_sec;

  always @(posedge clk_i) begin
    fifo_pop <= 1'b0;
    if (sys_rst_i) begin
      acc_done_ff   <= 1'b0;
      lsn_ff        <= 1'b0;
      tlk_ff        <= 1'b0;
      src_st_ff     <= ST_IDLE;
      settle_ff     <= 8'h00;
      atn_d_ff      <= 1'b0;
      dio_n_o       <= 8'hFF;
      dio_oe_n_o    <= 8'hFF;
      eoi_n_o       <= 1'b1;
      eoi_oe_n_o    <= 1'b1;
      srq_n_o       <= 1'b1;
      srq_oe_n_o    <= 1'b1;
      dav_n_o       <= 1'b1;
      dav_oe_n_o    <= 1'b1;
      nrfd_n_o      <= 1'b1;
      nrfd_oe_n_o   <= 1'b1;
      ndac_n_o      <= 1'b1;
      ndac_oe_n_o   <= 1'b1;
      rx_data_o     <= 8'h00;
      rx_eoi_o      <= 1'b0;
      rx_valid_o    <= 1'b0;
      rx_cmd_o      <= 1'b0;
      is_listener_o <= 1'b0;
      is_talker_o   <= 1'b0;
      remote_o      <= 1'b0;
      fifo_pop      <= 1'b0;
    end else begin
      atn_d_ff   <= atn;
      remote_o   <= ren;
      rx_valid_o <= 1'b0;
      rx_cmd_o   <= 1'b0;
      // settle counter after attention goes true
      if (atn && !atn_d_ff) begin
        settle_ff <= SETTLE;
      end else if (settle_ff != 8'h00) begin
        settle_ff <= settle_ff - 8'h01;
      end

      // acceptor handshake
      if (cap_now) begin
        acc_done_ff <= 1'b1;
        rx_data_o   <= bus_byte;
        rx_eoi_o    <= eoi;
        if (atn) begin
          rx_cmd_o <= 1'b1;
          if (hit_unl) begin
            lsn_ff <= 1'b0;
          end else if (hit_lsn) begin
            lsn_ff <= 1'b1;
          end
          if (hit_tlk) begin
            tlk_ff <= 1'b1;
            lsn_ff <= 1'b0;
          end else if (hit_othtlk) begin
            tlk_ff <= 1'b0; // other talk address or untalk
          end
        end else begin
          rx_valid_o <= 1'b1;
        end
      end else if (!dav) begin
        acc_done_ff <= 1'b0;
      end
      if (ifc) begin
        lsn_ff <= 1'b0;
        tlk_ff <= 1'b0;
      end
      // drive low only; releasing lets other listeners hold the line
      nrfd_oe_n_o <= !(acceptor_on && (acc_done_ff || cap_now || dav));
      nrfd_n_o    <= 1'b0;
      // not-accepted is let go at capture and pulled again once valid drops
      ndac_oe_n_o <= !(acceptor_on && !(acc_done_ff || cap_now));
      ndac_n_o    <= 1'b0;
      is_listener_o <= lsn_ff;
      is_talker_o   <= tlk_ff;

      // source handshake
      case (src_st_ff)
        ST_IDLE: begin
          dav_oe_n_o <= 1'b1;
          dio_oe_n_o <= 8'hFF;
          eoi_oe_n_o <= 1'b1;
          if (tlk_ff && !atn && fifo_valid) begin
            dio_n_o    <= ~fifo_out[7:0];
            dio_oe_n_o <= ~fifo_out[7:0];
            eoi_n_o    <= 1'b0;
            eoi_oe_n_o <= !fifo_out[8];
            src_st_ff  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (atn || !tlk_ff) begin
            src_st_ff <= ST_DROP;
          end else if (!nrfd && ndac && settle_ff == 8'h00) begin
            dav_n_o    <= 1'b0;
            dav_oe_n_o <= 1'b0;
            src_st_ff  <= ST_DAV;
          end
        end
        ST_DAV: begin
          if (!ndac) begin // all acceptors took the byte
            fifo_pop   <= 1'b1;
            src_st_ff  <= ST_DROP;
          end else if (atn) begin
            src_st_ff <= ST_DROP;
          end
        end
        ST_DROP: begin
          dav_oe_n_o <= 1'b1;
          dio_oe_n_o <= 8'hFF;
          eoi_oe_n_o <= 1'b1;
          src_st_ff  <= ST_IDLE;
        end
        default: begin
          src_st_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== gtli_core_assertions.sv
// Purpose: port checks for the talker/listener core
// Assumes: one clock, sync active-high reset
// Notes:   bound to gtli_core below
module gtli_chk (
  input wire logic       clk_i,         // clock
  input wire logic       sys_rst_i,     // reset
  input wire logic [7:0] dio_oe_n_o,    // data drive
  input wire logic       dav_oe_n_o,    // valid drive
  input wire logic       nrfd_oe_n_o,   // not-ready drive
  input wire logic       ndac_oe_n_o,   // not-accepted drive
  input wire logic       dav_n_i,       // valid line
  input wire logic       nrfd_n_i,      // not-ready line
  input wire logic       ndac_n_i,      // not-accepted line
  input wire logic       rx_valid_o,    // data pulse
  input wire logic       rx_cmd_o,      // command pulse
  input wire logic       is_listener_o, // listener
  input wire logic       is_talker_o    // talker
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_byte_taken;
    rx_valid_o || rx_cmd_o;
  endsequence
  sequence s_dav_gone;
    !nrfd_oe_n_o && $rose(dav_n_i);
  endsequence
  sequence s_src_acked;
    !dav_oe_n_o && ndac_n_i;
  endsequence
  a_reset_idle: assert property ($past(sys_rst_i) |-> &{dio_oe_n_o, dav_oe_n_o,
    nrfd_oe_n_o, ndac_oe_n_o} && !is_talker_o && !is_listener_o)
    else $error("device not idle after reset");
  a_talk_only: assert property (!is_talker_o && !$past(is_talker_o) |-> &dio_oe_n_o)
    else $error("data driven while not talker");
  a_one_role: assert property (!(is_talker_o && is_listener_o))
    else $error("talker and listener at once");
  a_dav_ready: assert property ($fell(dav_oe_n_o) |-> $past(nrfd_n_i) && !$past(ndac_n_i))
    else $error("valid asserted before acceptors ready");
  a_src_release: assert property (s_src_acked |-> ##[1:6] dav_oe_n_o)
    else $error("valid not withdrawn after accept");
  a_rx_pulse: assert property (rx_valid_o |-> is_listener_o ##1 !rx_valid_o)
    else $error("bad data pulse");
  a_accept_lines: assert property (s_byte_taken |-> !nrfd_oe_n_o && ndac_oe_n_o)
    else $error("wrong handshake drive at capture");
  a_ready_again: assert property (s_dav_gone |-> ##[1:6] nrfd_oe_n_o)
    else $error("not-ready held after valid dropped");
endmodule
bind gtli_core gtli_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .dio_oe_n_o(dio_oe_n_o),
  .dav_oe_n_o(dav_oe_n_o), .nrfd_oe_n_o(nrfd_oe_n_o), .ndac_oe_n_o(ndac_oe_n_o),
  .dav_n_i(dav_n_i), .nrfd_n_i(nrfd_n_i), .ndac_n_i(ndac_n_i), .rx_valid_o(rx_valid_o),
  .rx_cmd_o(rx_cmd_o), .is_listener_o(is_listener_o), .is_talker_o(is_talker_o));

// ===== gtli_ctl_model.sv
// Purpose: bus controller model, source and acceptor
// Assumes: pull-ups on all lines, low true
// Notes:   one controller and one device on this bus
module gtli_ctl_model (
  input  wire logic       clk_i,       // clock
  input  wire logic [7:0] dio_oe_n_i,  // device data drive
  input  wire logic       dav_oe_n_i,  // device valid drive
  input  wire logic       nrfd_oe_n_i, // device not-ready drive
  input  wire logic       ndac_oe_n_i, // device not-accepted drive
  output wire logic [7:0] dio_n_o,     // data lines
  output wire logic       dav_n_o,     // valid line
  output wire logic       nrfd_n_o,    // not-ready line
  output wire logic       ndac_n_o,    // not-accepted line
  output wire logic       atn_n_o,     // attention line
  output wire logic       got_o,       // byte taken pulse
  output wire logic [7:0] got_byte_o   // byte taken
);
  logic [7:0] dio_ff = 8'hFF, gotb_ff = 8'h00;
  logic       dav_ff = 1'b1, nrfd_ff = 1'b1, ndac_ff = 1'b1, atn_ff = 1'b1, got_ff = 1'b0;
  // wired lines: any party pulling low wins, released lines float high
  assign dio_n_o = dio_ff & dio_oe_n_i;
  assign dav_n_o = dav_ff & dav_oe_n_i;
  assign nrfd_n_o = nrfd_ff & nrfd_oe_n_i;
  assign ndac_n_o = ndac_ff & ndac_oe_n_i;
  assign atn_n_o = atn_ff;
  assign got_o = got_ff;
  assign got_byte_o = gotb_ff;
  task automatic send(input logic [7:0] b, input logic atn);
    int n;
    @(posedge clk_i);
    atn_ff <= !atn;
    dio_ff <= ~b;
    nrfd_ff <= 1'b1;
    ndac_ff <= 1'b1;
    repeat (12) @(posedge clk_i);
    for (n = 0; n < 200 && !(nrfd_n_o && !ndac_n_o); n++) @(posedge clk_i);
    dav_ff <= 1'b0;
    @(posedge clk_i);
    for (n = 0; n < 200 && !ndac_n_o; n++) @(posedge clk_i);
    dav_ff <= 1'b1;
    dio_ff <= 8'hFF;
  endtask
  task automatic take(input int stall);
    int n;
    @(posedge clk_i);
    atn_ff <= 1'b1;
    nrfd_ff <= 1'b0;
    ndac_ff <= 1'b0;
    repeat (stall + 1) @(posedge clk_i);
    nrfd_ff <= 1'b1;
    for (n = 0; n < 200 && dav_n_o; n++) @(posedge clk_i);
    gotb_ff <= ~dio_n_o;
    got_ff <= 1'b1;
    nrfd_ff <= 1'b0;
    ndac_ff <= 1'b1;
    @(posedge clk_i);
    got_ff <= 1'b0;
    for (n = 0; n < 200 && !dav_n_o; n++) @(posedge clk_i);
    ndac_ff <= 1'b0;
  endtask
endmodule

// ===== gpib_talk_listen_interface_tb.sv
// Purpose: self-checking bench for the talker/listener core
// Assumes: controller model on the far side of the bus
// Notes:   checker is bound to the core
module gpib_talk_listen_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0, sys_rst_i = 1'b1, tx_valid_i = 1'b0;
  logic [4:0] prim_addr_i;
  logic [7:0] tx_data_i = 8'h00, b;
  logic [7:0] rx_q[$], tx_q[$];
  wire  [7:0] dio_n, dio_oe_n, rx_data_o, got_byte;
  wire        dav_n, nrfd_n, ndac_n, atn_n, dav_oe_n, nrfd_oe_n, ndac_oe_n;
  wire        got, tx_ready_o, rx_valid_o, is_listener_o, is_talker_o;
  int         fails = 0, num_checks = 0, seed = 10362, n;
  always #5 clk_i = ~clk_i;
  gtli_core u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .prim_addr_i(prim_addr_i),
    .dio_n_i(dio_n), .dio_n_o(), .dio_oe_n_o(dio_oe_n), .atn_n_i(atn_n), .ifc_n_i(1'b1),
    .ren_n_i(1'b1), .eoi_n_i(1'b1), .eoi_n_o(), .eoi_oe_n_o(), .srq_n_o(), .srq_oe_n_o(),
    .dav_n_i(dav_n), .dav_n_o(), .dav_oe_n_o(dav_oe_n), .nrfd_n_i(nrfd_n), .nrfd_n_o(),
    .nrfd_oe_n_o(nrfd_oe_n), .ndac_n_i(ndac_n), .ndac_n_o(), .ndac_oe_n_o(ndac_oe_n),
    .tx_data_i(tx_data_i), .tx_last_i(1'b0), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_eoi_o(), .rx_valid_o(rx_valid_o), .rx_cmd_o(),
    .is_listener_o(is_listener_o), .is_talker_o(is_talker_o), .remote_o());
  gtli_ctl_model u_ctl (.clk_i(clk_i), .dio_oe_n_i(dio_oe_n), .dav_oe_n_i(dav_oe_n),
    .nrfd_oe_n_i(nrfd_oe_n), .ndac_oe_n_i(ndac_oe_n), .dio_n_o(dio_n), .dav_n_o(dav_n),
    .nrfd_n_o(nrfd_n), .ndac_n_o(ndac_n), .atn_n_o(atn_n), .got_o(got), .got_byte_o(got_byte));
  task automatic check(input logic [7:0] got_v, input logic [7:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic state(input logic [1:0] s);
    repeat (4) @(posedge clk_i);
    check({6'h00, is_listener_o, is_talker_o}, {6'h00, s});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1)
      check(rx_data_o, rx_q.size() ? rx_q.pop_front() : 8'hXX);
    if (got === 1'b1)
      check(got_byte, tx_q.size() ? tx_q.pop_front() : 8'hXX);
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    final_report;
  end
  initial begin
    // address 31 would alias the unlisten and untalk codes, so stay below it
    prim_addr_i <= 5'($unsigned($random(seed)) % 31);
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    u_ctl.send({3'h1, prim_addr_i}, 1'b1);
    state(2'b10);
    repeat (4) begin
      b = 8'($random(seed));
      rx_q.push_back(b);
      u_ctl.send(b, 1'b0);
    end
    u_ctl.send({3'h3, prim_addr_i}, 1'b1);
    state(2'b10);
    u_ctl.send(8'h3F, 1'b1);
    state(2'b00);
    u_ctl.send(8'($random(seed)), 1'b0);
    tx_data_i <= 8'($random(seed));
    tx_valid_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      if (tx_ready_o === 1'b1) begin
        tx_q.push_back(tx_data_i);
        tx_data_i <= 8'($random(seed));
        n++;
      end
    end while (tx_ready_o === 1'b1 && n < 12);
    tx_valid_i <= 1'b0;
    check(8'(n), 8'h08);
    u_ctl.send({3'h2, prim_addr_i}, 1'b1);
    state(2'b01);
    repeat (8) u_ctl.take($random(seed) & 7);
    u_ctl.send(8'h5F, 1'b1);
    state(2'b00);
    check(8'(rx_q.size() + tx_q.size()), 8'h00);
    final_report;
  end
endmodule
